/* bench/ptsm_assertions.sv */
module ptsm_chk (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        serial_packet_in,
  input wire logic        serial_packet_out,
  input wire logic        serial_packet_oe,
  input wire logic        second_pulse_oe,
  input wire logic        host_reload_req
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // Bus phases
  // ---------------------------------------------------------------
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bad_s;
    setup_s ##0 (paddr > 8'h44 || paddr[1:0] != 2'h0);
  endsequence
  sequence ctrl_wr_s;
    psel && penable && pwrite && pready && paddr == ptsm_pkg::A_CTRL;
  endsequence

  chk_ready_zero: assert property (setup_s |=> pready)
    else $error("no answer in access cycle");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  chk_err_bad: assert property (bad_s |=> pslverr && pready)
    else $error("bad address not refused");
  chk_err_read: assert property (bad_s ##0 !pwrite |=> prdata == 32'h0)
    else $error("refused read not zero");
  chk_err_good: assert property (setup_s ##0 !(paddr > 8'h44 || paddr[1:0] != 2'h0) |=> !pslverr)
    else $error("good address refused");
  chk_rdata_hold: assert property (pready && pwrite |-> $stable(prdata))
    else $error("read data moved on write");
  chk_out_off: assert property (ctrl_wr_s ##0 pwdata[6:4] == 3'h0 |=> ##1 !second_pulse_oe)
    else $error("pulse driven with no output");
  chk_out_on: assert property (ctrl_wr_s ##0 pwdata[6:4] != 3'h0 |=> ##1 second_pulse_oe)
    else $error("pulse output not enabled");
  chk_pkt_copy: assert property (serial_packet_oe && $past(serial_packet_oe)
    |-> serial_packet_out == $past(serial_packet_in))
    else $error("packet line not repeated");
  chk_reload_once: assert property (host_reload_req |=> !host_reload_req)
    else $error("reload request too long");
endmodule : ptsm_chk

bind ptsm_top ptsm_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_packet_in(serial_packet_in), .serial_packet_out(serial_packet_out),
  .serial_packet_oe(serial_packet_oe), .second_pulse_oe(second_pulse_oe),
  .host_reload_req(host_reload_req));

/* bench/ptsm_ref_src.sv */
module ptsm_ref_src (
  // Clock
  input  wire logic pclk,
  // Pulse pins
  output logic      line_pulse,
  output logic      host_pulse,
  output logic      aux_pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    line_pulse = 1'b0;
    host_pulse = 1'b0;
    aux_pulse  = 1'b0;
  end

  // Rising edges exactly gap cycles apart, high four cycles
  task automatic pulse(input int gap, input int src);
    repeat (gap - 4) @(posedge pclk);
    case (src)
      0: line_pulse <= 1'b1;
      1: host_pulse <= 1'b1;
      default: aux_pulse <= 1'b1;
    endcase
    repeat (4) @(posedge pclk);
    line_pulse <= 1'b0;
    host_pulse <= 1'b0;
    aux_pulse  <= 1'b0;
  endtask
endmodule : ptsm_ref_src

/* bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 1000;
  localparam int TOL = 50;
  logic        pclk, presetn, psel, penable, pwrite, pkt_in, pready, pslverr, err;
  logic        pkt_out, pkt_oe, sp_out, sp_oe, reload, line_p, host_p, aux_p;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, thr;
  int          error_cnt, tests_run, seed, since, tot, bad, sing, lng;
  bit          first;
  int          gaps[6] = '{1000, 1040, 2000, 500, 460, 1100};

  ptsm_top #(.SEC_CYC(SEC), .TOL_CYC(TOL)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_line_reference_input(line_p),
    .host_pulse(host_p), .aux_pulse(aux_p), .serial_packet_in(pkt_in),
    .serial_packet_out(pkt_out), .serial_packet_oe(pkt_oe), .second_pulse_out(sp_out),
    .second_pulse_oe(sp_oe), .host_reload_req(reload));
  ptsm_ref_src src_u (.pclk(pclk), .line_pulse(line_p), .host_pulse(host_p), .aux_pulse(aux_p));

  initial pclk = 1'b0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) pkt_in <= 1'($random(seed));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    if (n >= 100) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // Pulse statistics model
  // ---------------------------------------------------------------
  task automatic clr_model;
    tot = 0;
    bad = 0;
    sing = 0;
    lng = 0;
    since = 0;
    first = 1;
  endtask

  task automatic send(input int gap, input int src, input bit seen);
    src_u.pulse(gap, src);
    if (seen) begin
      tot++;
      since += gap;
      if (first) since = 0;
      else if (since >= SEC - TOL && since <= SEC + TOL) begin
        since = 0;
        lng = (lng < 1) ? 1 : lng;
      end else if (since >= 2 * SEC - TOL && since <= 2 * SEC + TOL) begin
        since = 0;
        sing++;
        lng = (lng < 2) ? 2 : lng;
      end else bad++;
      first = 0;
    end
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 38;
    error_cnt = 0;
    tests_run = 0;
    do_reset();
    apb(0, ptsm_pkg::A_CTRL, 0);
    chk("ctrl reset", rd, 32'h1);
    apb(0, ptsm_pkg::A_STATUS, 0);
    chk("status reset", rd & 32'h7, 32'h2);
    apb(0, ptsm_pkg::A_SYNTH, 0);
    chk("synth freq", rd, ptsm_pkg::SYNTH_HZ);
    apb(0, 8'h48, 0);
    chk("unmapped read", {rd[31:1], err}, 32'h1);
    apb(1, 8'h06, 32'hFFFF_FFFF);
    chk("unaligned write", {31'h0, err}, 32'h1);
    thr = $random(seed);
    apb(1, ptsm_pkg::A_THRESH, thr);
    apb(0, ptsm_pkg::A_THRESH, 0);
    chk("threshold", rd, thr);
    for (int o = 0; o < 5; o++) begin
      apb(1, ptsm_pkg::A_CTRL, 32'h1 | (32'(o) << 4));
      repeat (2) @(posedge pclk);
      chk("pulse oe", {31'h0, sp_oe}, {31'h0, o != 0});
      chk("packet oe", {31'h0, pkt_oe}, {31'h0, o == 1});
      apb(0, ptsm_pkg::A_CTRL, 0);
      chk("ctrl readback", rd, 32'h1 | (32'(o) << 4));
    end
    apb(1, ptsm_pkg::A_CTRL, 32'h0001_0001);
    clr_model();
    foreach (gaps[i]) send(gaps[i], 0, 1'b1);
    apb(0, ptsm_pkg::A_TOTAL, 0);
    chk("total", rd, tot);
    apb(0, ptsm_pkg::A_BAD, 0);
    chk("bad", rd, bad);
    apb(0, ptsm_pkg::A_SINGLES, 0);
    chk("singles", rd, sing);
    apb(0, ptsm_pkg::A_LONGEST, 0);
    chk("longest", rd, lng);
    apb(1, ptsm_pkg::A_CTRL, 32'h0001_0001);
    for (int a = 8'h1C; a <= 8'h38; a += 4) begin
      if (a == 8'h24 || a == 8'h28) continue;
      apb(0, 8'(a), 0);
      chk("cleared stat", rd, 32'h0);
    end
    do_reset();
    clr_model();
    thr = $random(seed);
    apb(1, ptsm_pkg::A_SET_SEC, thr);
    apb(1, ptsm_pkg::A_CTRL, 32'h0002_0001);
    for (int s = 0; s < 4; s++) begin
      apb(1, ptsm_pkg::A_CTRL, (s == 0) ? 32'h1 : (s == 1) ? 32'h2 : (s == 2) ? 32'h4 : 32'h0);
      send(SEC, s % 3, s < 3);
      send(SEC, (s + 1) % 3, 1'b0);
      apb(0, ptsm_pkg::A_TOTAL, 0);
      chk("selected input", rd, tot);
    end
    apb(0, ptsm_pkg::A_LATCH_SEC, 0);
    chk("latched seconds", rd, thr);
    apb(1, ptsm_pkg::A_CTRL, 32'h33);
    for (int k = 0; k < 2; k++) begin
      since = 0;
      do begin
        @(posedge pclk);
        since++;
      end while (sp_out !== 1'b1 && since < 3 * SEC);
    end
    chk("master period", since, SEC);
    finish_test();
  end
endmodule : tb_top

/* design/ptsm_cnt.sv */
// Saturating statistics counter with clear
module ptsm_cnt #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         clr,
  input  wire logic         inc,
  // Value
  output logic [W-1:0]      cnt_r
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (clr) begin
      cnt_r <= '0;
    end else if (inc && (cnt_r != {W{1'b1}})) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // ptsm_cnt

/* design/ptsm_pkg.sv */
package ptsm_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_THRESH    = 8'h04;
  localparam logic [7:0] A_STATUS    = 8'h08;
  localparam logic [7:0] A_FAILS     = 8'h0C;
  localparam logic [7:0] A_RESYNCS   = 8'h10;
  localparam logic [7:0] A_FREQ_ERR  = 8'h14;
  localparam logic [7:0] A_PHASE_ERR = 8'h18;
  localparam logic [7:0] A_WORST_F   = 8'h1C;
  localparam logic [7:0] A_WORST_P   = 8'h20;
  localparam logic [7:0] A_ACTUAL    = 8'h24;
  localparam logic [7:0] A_SYNTH     = 8'h28;
  localparam logic [7:0] A_TOTAL     = 8'h2C;
  localparam logic [7:0] A_BAD       = 8'h30;
  localparam logic [7:0] A_SINGLES   = 8'h34;
  localparam logic [7:0] A_LONGEST   = 8'h38;
  localparam logic [7:0] A_LATCH_SEC = 8'h3C;
  localparam logic [7:0] A_LATCH_FRC = 8'h40;
  localparam logic [7:0] A_SET_SEC   = 8'h44;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int CTRL_IN_LSB   = 0;  // 3 bits input select
  localparam int CTRL_OUT_LSB  = 4;  // 3 bits output select
  localparam int CTRL_HTYPE    = 8;  // host flavour: 0 unix 1 windows
  localparam int CTRL_CLR      = 16; // write 1: clear statistics
  localparam int CTRL_SET      = 17; // write 1: load time, clear stats
  localparam int CTRL_RESET    = 18; // write 1: full clock reset

  localparam int STAT_SYNC     = 0;
  localparam int STAT_FREE     = 1;
  localparam int STAT_RELOAD   = 2;

  typedef enum logic [2:0] {
    PTSM_IN_NONE, PTSM_IN_LINE, PTSM_IN_HOST, PTSM_IN_INT, PTSM_IN_AUX
  } ptsm_in_t;
  typedef enum logic [2:0] {
    PTSM_OUT_NONE, PTSM_OUT_REPEAT, PTSM_OUT_HOST, PTSM_OUT_INT, PTSM_OUT_LOOP
  } ptsm_out_t;

  // ---------------------------------------------------------------
  // Thresholds and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] THR_LINE_NS    = 32'd596;
  localparam logic [31:0] THR_UNIX_NS    = 32'd12000;
  localparam logic [31:0] THR_WIN_NS     = 32'd50000;
  localparam int          CLK_NS         = 4;
  localparam logic [31:0] SEC_NS         = 32'd1000000000;
  localparam int          SEC_CYCLES     = 1000000000 / CLK_NS;
  localparam int          TOL_NS         = 1000000;
  localparam int          TOL_CYCLES     = TOL_NS / CLK_NS;
  localparam logic [3:0]  UNSYNC_SECS    = 4'd10;
  localparam logic [31:0] PPB_SCALE      = 32'd4;
  localparam logic [31:0] SYNTH_HZ       = 32'h0400_0000;
endpackage : ptsm_pkg

/* design/ptsm_top.sv */
// Summary of operation
// - Input source selectable: line, host, internal, auxiliary or none.
// - Output source selectable: repeat line, host, internal, loop or none.
// - Phase error over threshold for 10 seconds running loses sync.
// - Default threshold 596 ns line, 12000 ns unix, 50000 ns windows host.
// - Software may program its own threshold in nanoseconds.
// - Failure count grows at each entry into not synchronized.
// - Resync count grows each time phase error exceeds one second.
// - Unsynced over 10 seconds: reload host time, clear statistics.
// - Frequency error of last second reported in ppb.
// - Phase error is local clock minus reference at last pulse.
// - Worst absolute frequency and phase errors held, cleared on stats reset.
// - Every received pulse counted, cleared on stats reset.
// - Pulse neither about one nor about two seconds after previous is bad and counted.
// - Two-second gap counts one single missed pulse.
// - Longest gap in seconds between pulses held, cleared on stats reset.
// - Time latched at each pulse not counted bad; never synced shows free running.
// - Actual crystal frequency measured; synthesized frequency reported.
// - Valid reference pulse starts sync without intervention.
// - Link carries pulse on circuit A, serial packet on circuit B.
// - Master drives internal pulse out; default slave listens on line input.
// - All statistics clear on load, clear command, set or full reset.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
module ptsm_top #(
  parameter int SEC_CYC = ptsm_pkg::SEC_CYCLES,
  parameter int TOL_CYC = ptsm_pkg::TOL_CYCLES
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pulse sources
  input  wire logic        serial_line_reference_input,
  input  wire logic        host_pulse,
  input  wire logic        aux_pulse,
  // Circuit B serial packet pin, pass-through
  input  wire logic        serial_packet_in,
  output logic             serial_packet_out,
  output logic             serial_packet_oe,
  // Pulse output, circuit A
  output logic             second_pulse_out,
  output logic             second_pulse_oe,
  // Host time reload request
  output logic             host_reload_req
);
  localparam int CW = 32;

  // -------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------
  logic [2:0]    in_sel_r, out_sel_r;
  logic [31:0]   thresh_prog_r, set_sec_r;
  logic          host_win_r, clr_cmd, set_cmd, rst_cmd, wr_en, rd_en, addr_ok;

  // Pulse tracking
  logic          sel_pulse, sel_d_r, pulse_ev, int_pulse_r;
  logic [CW-1:0] gap_r, sec_cnt_r, int_cnt_r;
  logic [31:0]   gap_secs_r;

  // Timebase
  logic [31:0]   tb_sec_r, tb_frac_r, lat_sec_r, lat_frac_r;

  // Sync tracking
  logic          synced_r, ever_r, first_r, upd_r;
  logic [3:0]    over_cnt_r, unsync_cnt_r;
  logic [31:0]   phase_r, freq_r, worst_f_r, worst_p_r, actual_r;
  logic [31:0]   thresh, abs_phase, abs_freq;
  logic          good_ev, bad_ev, single_ev, fail_ev, resync_ev, auto_set, stats_clr;
  logic [31:0]   total_c, bad_c, single_c, fail_c, resync_c;

  // -------------------------------------------------------------
  // APB slave
  // -------------------------------------------------------------
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = (paddr <= ptsm_pkg::A_SET_SEC) && (paddr[1:0] == 2'b00);
  assign clr_cmd = wr_en && addr_ok && (paddr == ptsm_pkg::A_CTRL)
                   && pwdata[ptsm_pkg::CTRL_CLR];
  assign set_cmd = wr_en && (paddr == ptsm_pkg::A_CTRL) && pwdata[ptsm_pkg::CTRL_SET];
  assign rst_cmd = wr_en && (paddr == ptsm_pkg::A_CTRL) && pwdata[ptsm_pkg::CTRL_RESET];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sel_r      <= ptsm_pkg::PTSM_IN_LINE;
      out_sel_r     <= ptsm_pkg::PTSM_OUT_NONE;
      host_win_r    <= 1'b0;
      thresh_prog_r <= 32'h0000_0000;
      set_sec_r     <= 32'h0000_0000;
    end else if (wr_en && addr_ok) begin
      if (paddr == ptsm_pkg::A_CTRL) begin
        if (pwdata[ptsm_pkg::CTRL_RESET]) begin
          in_sel_r  <= ptsm_pkg::PTSM_IN_LINE;
          out_sel_r <= ptsm_pkg::PTSM_OUT_NONE;
        end else begin
          in_sel_r  <= pwdata[ptsm_pkg::CTRL_IN_LSB +: 3];
          out_sel_r <= pwdata[ptsm_pkg::CTRL_OUT_LSB +: 3];
        end
        host_win_r <= pwdata[ptsm_pkg::CTRL_HTYPE];
      end
      if (paddr == ptsm_pkg::A_THRESH) thresh_prog_r <= pwdata;
      if (paddr == ptsm_pkg::A_SET_SEC) set_sec_r <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        ptsm_pkg::A_CTRL:      prdata <= {23'h0, host_win_r, 1'b0, out_sel_r, 1'b0, in_sel_r};
        ptsm_pkg::A_THRESH:    prdata <= thresh;
        ptsm_pkg::A_STATUS:    prdata <= {29'h0, host_reload_req, !ever_r, synced_r};
        ptsm_pkg::A_FAILS:     prdata <= fail_c;
        ptsm_pkg::A_RESYNCS:   prdata <= resync_c;
        ptsm_pkg::A_FREQ_ERR:  prdata <= freq_r;
        ptsm_pkg::A_PHASE_ERR: prdata <= phase_r;
        ptsm_pkg::A_WORST_F:   prdata <= worst_f_r;
        ptsm_pkg::A_WORST_P:   prdata <= worst_p_r;
        ptsm_pkg::A_ACTUAL:    prdata <= actual_r;
        ptsm_pkg::A_SYNTH:     prdata <= ptsm_pkg::SYNTH_HZ;
        ptsm_pkg::A_TOTAL:     prdata <= total_c;
        ptsm_pkg::A_BAD:       prdata <= bad_c;
        ptsm_pkg::A_SINGLES:   prdata <= single_c;
        ptsm_pkg::A_LONGEST:   prdata <= gap_secs_r;
        ptsm_pkg::A_LATCH_SEC: prdata <= lat_sec_r;
        ptsm_pkg::A_LATCH_FRC: prdata <= lat_frac_r;
        ptsm_pkg::A_SET_SEC:   prdata <= set_sec_r;
        default:               prdata <= 32'h0000_0000;
      endcase
    end
  end

  // -------------------------------------------------------------
  // Threshold choice
  // -------------------------------------------------------------
  always_comb begin
    if (thresh_prog_r != 32'h0000_0000) begin
      thresh = thresh_prog_r;
    end else if (in_sel_r == ptsm_pkg::PTSM_IN_LINE) begin
      thresh = ptsm_pkg::THR_LINE_NS;
    end else if (host_win_r) begin
      thresh = ptsm_pkg::THR_WIN_NS;
    end else begin
      thresh = ptsm_pkg::THR_UNIX_NS;
    end
  end

  // -------------------------------------------------------------
  // Input mux and internal master pulse
  // -------------------------------------------------------------
  always_comb begin
    unique case (in_sel_r)
      ptsm_pkg::PTSM_IN_LINE: sel_pulse = serial_line_reference_input;
      ptsm_pkg::PTSM_IN_HOST: sel_pulse = host_pulse;
      ptsm_pkg::PTSM_IN_INT:  sel_pulse = int_pulse_r;
      ptsm_pkg::PTSM_IN_AUX:  sel_pulse = aux_pulse;
      default:                sel_pulse = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt_r   <= '0;
      int_pulse_r <= 1'b0;
    end else begin
      int_pulse_r <= (int_cnt_r == CW'(SEC_CYC - 1));
      int_cnt_r   <= (int_cnt_r == CW'(SEC_CYC - 1)) ? '0 : int_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_pulse_out  <= 1'b0;
      second_pulse_oe   <= 1'b0;
      serial_packet_out <= 1'b0;
      serial_packet_oe  <= 1'b0;
    end else begin
      unique case (out_sel_r)
        ptsm_pkg::PTSM_OUT_REPEAT: second_pulse_out <= serial_line_reference_input;
        ptsm_pkg::PTSM_OUT_HOST:   second_pulse_out <= host_pulse;
        ptsm_pkg::PTSM_OUT_INT:    second_pulse_out <= int_pulse_r;
        ptsm_pkg::PTSM_OUT_LOOP:   second_pulse_out <= sel_pulse;
        default:                   second_pulse_out <= 1'b0;
      endcase
      second_pulse_oe   <= (out_sel_r != ptsm_pkg::PTSM_OUT_NONE);
      serial_packet_out <= serial_packet_in;
      serial_packet_oe  <= (out_sel_r == ptsm_pkg::PTSM_OUT_REPEAT);
    end
  end

  // -------------------------------------------------------------
  // Pulse edge, interval check
  // -------------------------------------------------------------
  assign pulse_ev  = sel_pulse && !sel_d_r;
  assign good_ev   = pulse_ev && (first_r || ((gap_r >= CW'(SEC_CYC - TOL_CYC))
                     && (gap_r <= CW'(SEC_CYC + TOL_CYC))));
  assign single_ev = pulse_ev && !first_r && (gap_r >= CW'(2 * SEC_CYC - TOL_CYC))
                     && (gap_r <= CW'(2 * SEC_CYC + TOL_CYC));
  assign bad_ev    = pulse_ev && !good_ev && !single_ev;
  assign stats_clr = clr_cmd || set_cmd || rst_cmd || auto_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_d_r    <= 1'b0;
      gap_r      <= '0;
      sec_cnt_r  <= '0;
      gap_secs_r <= 32'h0000_0000;
      first_r    <= 1'b1;
    end else begin
      sel_d_r <= sel_pulse;
      if (pulse_ev && !bad_ev) begin
        gap_r     <= CW'(1); // Pulse cycle itself counts
        sec_cnt_r <= '0;
        first_r   <= 1'b0;
      end else begin
        gap_r <= (gap_r == {CW{1'b1}}) ? gap_r : gap_r + 1'b1;
        if (sec_cnt_r == CW'(SEC_CYC - 1)) begin
          sec_cnt_r <= '0;
        end else begin
          sec_cnt_r <= sec_cnt_r + 1'b1;
        end
      end
      if (stats_clr) begin
        gap_secs_r <= 32'h0000_0000;
        first_r    <= 1'b1;
      end else if (pulse_ev && !first_r && (gap_r / CW'(SEC_CYC)) > gap_secs_r) begin
        gap_secs_r <= gap_r / CW'(SEC_CYC);
      end
    end
  end

  // -------------------------------------------------------------
  // Timebase, latch and error measurement
  // -------------------------------------------------------------
  assign abs_phase = phase_r[31] ? -phase_r : phase_r;
  assign abs_freq  = freq_r[31] ? -freq_r : freq_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_sec_r  <= 32'h0000_0000;
      tb_frac_r <= 32'h0000_0000;
    end else if (set_cmd || rst_cmd || auto_set) begin
      tb_sec_r  <= set_sec_r;
      tb_frac_r <= 32'h0000_0000;
    end else if (good_ev && !first_r) begin
      tb_sec_r  <= tb_sec_r + 1'b1;
      tb_frac_r <= 32'h0000_0000;
    end else if (tb_frac_r >= ptsm_pkg::SEC_NS - 32'(ptsm_pkg::CLK_NS)) begin
      tb_sec_r  <= tb_sec_r + 1'b1;
      tb_frac_r <= 32'h0000_0000;
    end else begin
      tb_frac_r <= tb_frac_r + 32'(ptsm_pkg::CLK_NS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_sec_r  <= 32'h0000_0000;
      lat_frac_r <= 32'h0000_0000;
      phase_r    <= 32'h0000_0000;
      freq_r     <= 32'h0000_0000;
      actual_r   <= 32'h0000_0000;
      worst_f_r  <= 32'h0000_0000;
      worst_p_r  <= 32'h0000_0000;
      upd_r      <= 1'b0;
    end else begin
      upd_r <= pulse_ev && !bad_ev;
      if (pulse_ev && !bad_ev) begin
        lat_sec_r  <= tb_sec_r;
        lat_frac_r <= tb_frac_r;
        phase_r    <= (tb_frac_r >= (ptsm_pkg::SEC_NS >> 1)) ?
                      tb_frac_r - ptsm_pkg::SEC_NS : tb_frac_r;
      end
      if (good_ev && !first_r) begin
        actual_r <= gap_r;
        freq_r   <= (gap_r - CW'(SEC_CYC)) * ptsm_pkg::PPB_SCALE;
      end
      if (stats_clr) begin
        worst_f_r <= 32'h0000_0000;
        worst_p_r <= 32'h0000_0000;
      end else if (upd_r) begin
        if (abs_freq > worst_f_r) worst_f_r <= abs_freq;
        if (abs_phase > worst_p_r) worst_p_r <= abs_phase;
      end
    end
  end

  // -------------------------------------------------------------
  // Sync state, once per second
  // -------------------------------------------------------------
  assign resync_ev = pulse_ev && !bad_ev && (tb_sec_r != lat_sec_r + 1'b1)
                     && !first_r;
  assign fail_ev   = synced_r && (sec_cnt_r == CW'(SEC_CYC - 1))
                     && (over_cnt_r == ptsm_pkg::UNSYNC_SECS - 1'b1)
                     && (abs_phase > thresh);
  assign auto_set  = !synced_r && ever_r && (sec_cnt_r == CW'(SEC_CYC - 1))
                     && (unsync_cnt_r == ptsm_pkg::UNSYNC_SECS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synced_r        <= 1'b0;
      ever_r          <= 1'b0;
      over_cnt_r      <= 4'h0;
      unsync_cnt_r    <= 4'h0;
      host_reload_req <= 1'b0;
    end else begin
      host_reload_req <= auto_set;
      if (rst_cmd || set_cmd || auto_set) begin
        synced_r     <= 1'b0;
        over_cnt_r   <= 4'h0;
        unsync_cnt_r <= 4'h0;
      end else begin
        if (good_ev && !first_r && abs_phase <= thresh) begin
          synced_r <= 1'b1;
          ever_r   <= 1'b1;
        end
        if (sec_cnt_r == CW'(SEC_CYC - 1)) begin
          if (abs_phase > thresh) begin
            over_cnt_r <= (over_cnt_r == ptsm_pkg::UNSYNC_SECS) ? over_cnt_r
                          : over_cnt_r + 1'b1;
          end else begin
            over_cnt_r <= 4'h0;
          end
          if (fail_ev) synced_r <= 1'b0;
          unsync_cnt_r <= synced_r ? 4'h0 :
                          (unsync_cnt_r == ptsm_pkg::UNSYNC_SECS) ? unsync_cnt_r
                          : unsync_cnt_r + 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // Statistics counters
  // -------------------------------------------------------------
  ptsm_cnt #(.W(32)) u_total  (.pclk(pclk), .presetn(presetn), .clr(stats_clr),
    .inc(pulse_ev), .cnt_r(total_c));
  ptsm_cnt #(.W(32)) u_bad    (.pclk(pclk), .presetn(presetn), .clr(stats_clr),
    .inc(bad_ev), .cnt_r(bad_c));
  ptsm_cnt #(.W(32)) u_single (.pclk(pclk), .presetn(presetn), .clr(stats_clr),
    .inc(single_ev), .cnt_r(single_c));
  ptsm_cnt #(.W(32)) u_fail   (.pclk(pclk), .presetn(presetn), .clr(stats_clr),
    .inc(fail_ev), .cnt_r(fail_c));
  ptsm_cnt #(.W(32)) u_resync (.pclk(pclk), .presetn(presetn), .clr(stats_clr),
    .inc(resync_ev), .cnt_r(resync_c));
endmodule // ptsm_top
